// ==== verification/dpda_ctrl_model.sv ====
// Model of the two controllers: collects pending status after a lag.
// Assumes pending is a level that drops the edge after collection.
module dpda_ctrl_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [1:0] status_pending,
	input wire logic [3:0] lag,
	output logic [1:0] status_taken
);
	timeunit 1ns;
	timeprecision 1ps;
	// Lag 0 answers at once; a long lag shows that pending waits for us
	for (genvar p = 0; p < 2; p++) begin : g_port
		logic [3:0] age;
		logic take;
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				age <= 4'h0;
				take <= 1'b0;
			end else begin
				take <= 1'b0;
				if (!status_pending[p] || take)
					age <= 4'h0;
				else if (age >= lag)
					take <= 1'b1;
				else
					age <= age + 4'h1;
			end
		end
		assign status_taken[p] = take;
	end
endmodule

// ==== verification/dpda_top_chk.sv ====
// Checker on the ports of the drive access block.
// Assumes one clock domain and the active low asynchronous reset.
module dpda_top_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic pready,
	input wire logic drive_ready,
	input wire logic [1:0] port_enabled,
	input wire logic [1:0] sel_req,
	input wire logic [1:0] prio_select,
	input wire logic [1:0] port_reset,
	input wire logic [1:0] cmd_valid,
	input wire logic [1:0] cmd_needs_hda,
	input wire logic time_dep_done,
	input wire logic [1:0] status_taken,
	input wire logic [1:0] slave_in,
	input wire logic [1:0] radial_addr_valid,
	input wire logic [1:0] selected,
	input wire logic [1:0] switched,
	input wire logic [1:0] cmd_accept,
	input wire logic [1:0] status_busy,
	input wire logic [1:0] op_exception,
	input wire logic [1:0] out_of_context,
	input wire logic [1:0] completion_irq,
	input wire logic [1:0] status_pending,
	input wire logic cmd_active
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_one_selected: assert property (!(selected[0] && selected[1]))
		else $error("both ports selected");
	a_busy_answer: assert property (selected[1] && sel_req[0] &&
		port_enabled[0] && !prio_select[0] && !port_reset[0]
		|=> slave_in[0] && !radial_addr_valid[0] && !selected[0])
		else $error("busy port not answered without address");
	a_accept_cause: assert property (cmd_accept != 2'h0
		|-> (cmd_accept & $past(cmd_valid & selected)) == cmd_accept)
		else $error("accept without selected command");
	a_active_refuse: assert property (cmd_active && !time_dep_done &&
		(cmd_valid & selected) != 2'h0
		|=> cmd_accept == 2'h0 && status_busy != 2'h0)
		else $error("command taken while active");
	a_hda_reject: assert property ((cmd_valid & selected & cmd_needs_hda)
		!= 2'h0 && !drive_ready && !cmd_active
		|=> op_exception != 2'h0 && out_of_context == op_exception)
		else $error("not ready command not rejected");
	a_done_irq: assert property (cmd_active && time_dep_done
		|=> !cmd_active && completion_irq != 2'h0)
		else $error("completion not signalled");
	a_pending_hold: assert property (status_pending[0] && !psel &&
		!pready && !status_taken[0] && !port_reset[0] && port_enabled[0]
		|=> status_pending[0])
		else $error("pending lost before collection");
	a_reset_neutral: assert property ($rose(presetn) |->
		switched == 2'h0 && selected == 2'h0 && status_pending == 2'h0)
		else $error("not neutral after reset");
	a_switch_follow: assert property ((selected & ~switched) == 2'h0 &&
		switched != 2'h3)
		else $error("switch not held by the selected port alone");

	c_busy: cover property (slave_in[0] && !radial_addr_valid[0]);
	c_accept: cover property (cmd_accept != 2'h0);
	c_done: cover property (completion_irq != 2'h0);
	c_hda: cover property (out_of_context != 2'h0);
endmodule

bind dpda_top dpda_top_chk u_dpda_top_chk (
	.pclk, .presetn, .psel, .pready, .drive_ready, .port_enabled,
	.sel_req, .prio_select, .port_reset, .cmd_valid, .cmd_needs_hda,
	.time_dep_done, .status_taken, .slave_in, .radial_addr_valid,
	.selected, .switched, .cmd_accept, .status_busy, .op_exception,
	.out_of_context, .completion_irq, .status_pending, .cmd_active
);

// ==== verification/dpda_top_tb.sv ====
// Self-checking bench for the drive access block.
// Assumes the controller model collects status; APB from here.
module dpda_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dpda_pkg::*;
	localparam logic [15:0] DEF_S = 16'h0018;
	localparam logic [15:0] MFR_S = 16'h0020;
	localparam logic [31:0] NEU = 32'h1 << DPDA_ST_NEUTRAL;
	logic pclk, presetn, psel, penable, pwrite, drive_ready, time_dep_done;
	logic pready, pslverr, rd_err, cmd_active;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd_val;
	logic [1:0] port_enabled, sel_req, prio_select, reserve, prio_reserve;
	logic [1:0] release_req, port_reset, cmd_valid, cmd_time_dep;
	logic [1:0] cmd_needs_hda, cmd_needs_format, status_taken, slave_in;
	logic [1:0] radial_addr_valid, selected, switched, cmd_accept;
	logic [1:0] status_busy, op_exception, out_of_context, completion_irq;
	logic [1:0] status_pending;
	logic [3:0] lag;
	int err_total, tests_run;

	dpda_top #(.DEF_SECTORS(DEF_S), .DEF_FIELDS(16'h0003),
		.MFR_SECTORS(MFR_S)) u_dpda_top (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .drive_ready, .port_enabled, .sel_req,
		.prio_select, .reserve, .prio_reserve, .release_req, .port_reset,
		.cmd_valid, .cmd_time_dep, .cmd_needs_hda, .cmd_needs_format,
		.time_dep_done, .status_taken, .slave_in, .radial_addr_valid,
		.selected, .switched, .cmd_accept, .status_busy, .op_exception,
		.out_of_context, .completion_irq, .status_pending, .cmd_active);
	dpda_ctrl_model u_dpda_ctrl_model (.pclk, .presetn, .status_pending,
		.lag, .status_taken);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd_val = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			err_total++;
	endtask

	task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, rd_val, e);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task cyc(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	task sel(input logic [1:0] v);
		@(posedge pclk);
		sel_req <= v;
		cyc(1);
	endtask

	task cmd(input logic [1:0] p, input logic t, input logic h,
		input logic f);
		@(posedge pclk);
		cmd_valid <= p;
		cmd_time_dep <= {2{t}};
		cmd_needs_hda <= {2{h}};
		cmd_needs_format <= {2{f}};
		@(posedge pclk);
		cmd_valid <= 2'h0;
		#1;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_reset;
		rd("status", DPDA_OFF_STATUS, NEU);
		rd("flags", DPDA_OFF_FMT_FLAGS, {24'h0, DPDA_RST_FLAGS});
		apb(1'b1, 8'h18, 32'h0);
		chk("unmapped", {31'h0, rd_err}, 32'h1);
		apb(1'b1, DPDA_OFF_STATUS, 32'h0);
		chk("ro_status", {31'h0, rd_err}, 32'h1);
	endtask

	task t_format;
		wr(DPDA_OFF_FMT_FLAGS, 32'h0);
		wr(DPDA_OFF_FMT_SECTORS, {16'h0, DPDA_ALL_ONES});
		wr(DPDA_OFF_FMT_FIELDS, 32'h2);
		wr(DPDA_OFF_FMT_LOAD, 32'h0);
		rd("init_flag", DPDA_OFF_FMT_FLAGS, 32'h80);
		rd("calc_sect", DPDA_OFF_FMT_SECTORS, {16'h0, DEF_S});
		wr(DPDA_OFF_FMT_FLAGS, 32'h80);
		wr(DPDA_OFF_FMT_SECTORS, 32'h10);
		wr(DPDA_OFF_FMT_FIELDS, 32'h5);
		wr(DPDA_OFF_FMT_LOAD, 32'h0);
		rd("bad_flag", DPDA_OFF_FMT_FLAGS, 32'h0);
		rd("bad_stat", DPDA_OFF_STATUS, NEU | 32'h400);
		sel(2'h1);
		cmd(2'h1, 1'b0, 1'b0, 1'b1);
		chk("fmt_refuse", {28'h0, op_exception, cmd_accept}, 32'h4);
		sel(2'h0);
		wr(DPDA_OFF_FMT_FIELDS, 32'h3);
		wr(DPDA_OFF_FMT_LOAD, 32'h0);
		rd("full_sect", DPDA_OFF_FMT_SECTORS, 32'h10);
		wr(DPDA_OFF_FMT_FLAGS, 32'h40);
		wr(DPDA_OFF_FMT_LOAD, 32'h0);
		rd("mfr_flags", DPDA_OFF_FMT_FLAGS, 32'hC0);
		rd("mfr_fields", DPDA_OFF_FMT_FIELDS, 32'h2);
		rd("mfr_sect", DPDA_OFF_FMT_SECTORS, {16'h0, MFR_S});
	endtask

	task t_select;
		sel(2'h3);
		chk("arbitrate", {30'h0, selected}, 32'h2);
		cyc(1);
		chk("busy_ans", {28'h0, slave_in, radial_addr_valid}, 32'hE);
		sel(2'h1);
		chk("unswitch", {30'h0, switched}, 32'h0);
		cyc(1);
		chk("neutral", {30'h0, selected}, 32'h1);
		sel(2'h0);
	endtask

	task t_reserve;
		sel(2'h1);
		@(posedge pclk);
		reserve <= 2'h1;
		@(posedge pclk);
		reserve <= 2'h0;
		sel(2'h2);
		cyc(1);
		chk("reserved", {28'h0, switched, selected}, 32'h4);
		@(posedge pclk);
		prio_select <= 2'h2;
		@(posedge pclk);
		prio_select <= 2'h0;
		#1;
		chk("prio_sel", {28'h0, switched, selected}, 32'hA);
		@(posedge pclk);
		prio_reserve <= 2'h2;
		@(posedge pclk);
		prio_reserve <= 2'h0;
		sel(2'h1);
		@(posedge pclk);
		prio_select <= 2'h1;
		@(posedge pclk);
		prio_select <= 2'h0;
		#1;
		chk("prio_hold", {28'h0, switched, selected}, 32'h8);
		@(posedge pclk);
		port_reset <= 2'h2;
		@(posedge pclk);
		port_reset <= 2'h0;
		cyc(1);
		chk("reset_port", {28'h0, switched, selected}, 32'h5);
		@(posedge pclk);
		reserve <= 2'h1;
		@(posedge pclk);
		reserve <= 2'h0;
		sel(2'h0);
		chk("held", {30'h0, switched}, 32'h1);
		wr(DPDA_OFF_CTRL, 32'h1);
		cyc(1);
		chk("drv_reset", {30'h0, switched}, 32'h0);
		rd("kept_fmt", DPDA_OFF_FMT_FLAGS, 32'hC0);
	endtask

	task t_cmd;
		lag <= 4'hF;
		sel(2'h1);
		cmd(2'h1, 1'b1, 1'b0, 1'b1);
		chk("accept", {30'h0, cmd_accept}, 32'h1);
		cmd(2'h1, 1'b0, 1'b0, 1'b0);
		chk("st_busy", {29'h0, cmd_active, status_busy}, 32'h5);
		sel(2'h2);
		cyc(1);
		chk("timed_busy", {28'h0, slave_in, selected}, 32'h8);
		@(posedge pclk);
		time_dep_done <= 1'b1;
		@(posedge pclk);
		time_dep_done <= 1'b0;
		#1;
		chk("done", {27'h0, cmd_active, completion_irq, status_pending},
			32'h5);
		cyc(1);
		chk("freed", {30'h0, selected}, 32'h2);
		cyc(8);
		chk("pend_held", {30'h0, status_pending}, 32'h1);
		cyc(12);
		chk("pend_taken", {30'h0, status_pending}, 32'h0);
		@(posedge pclk);
		lag <= 4'h0;
		drive_ready <= 1'b0;
		cmd(2'h2, 1'b0, 1'b1, 1'b0);
		chk("not_ready", {28'h0, op_exception, out_of_context}, 32'hA);
		@(posedge pclk);
		drive_ready <= 1'b1;
		cmd(2'h2, 1'b0, 1'b0, 1'b0);
		chk("untimed", {30'h0, cmd_accept}, 32'h2);
		cyc(6);
		chk("prompt", {30'h0, status_pending}, 32'h0);
		sel(2'h0);
	endtask

	task complete_run;
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		{presetn, psel, penable, pwrite, time_dep_done} = 5'h0;
		{sel_req, prio_select, reserve, prio_reserve} = 8'h0;
		{release_req, port_reset, cmd_valid, cmd_time_dep} = 8'h0;
		{cmd_needs_hda, cmd_needs_format} = 4'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		port_enabled = 2'h3;
		drive_ready = 1'b1;
		lag = 4'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_format;
		t_select;
		t_reserve;
		t_cmd;
		complete_run;
	end

	// Whole run is a few hundred cycles; this limit only cuts a hang
	initial begin
		#200000;
		err_total++;
		complete_run;
	end
endmodule

// ==== verilog/dpda_pkg.sv ====
// Package for the dual port drive access block: register map,
// field positions, reset values and format constants.
// Assumes a 32-bit APB master and one clock domain.
package dpda_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] DPDA_OFF_CTRL = 8'h00;
	localparam logic [7:0] DPDA_OFF_STATUS = 8'h04;
	localparam logic [7:0] DPDA_OFF_FMT_FLAGS = 8'h08;
	localparam logic [7:0] DPDA_OFF_FMT_SECTORS = 8'h0C;
	localparam logic [7:0] DPDA_OFF_FMT_FIELDS = 8'h10;
	localparam logic [7:0] DPDA_OFF_FMT_LOAD = 8'h14;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int DPDA_CTRL_DRIVE_RESET = 0;
	localparam int DPDA_FLAG_INITIALIZED = 7;
	localparam int DPDA_FLAG_MFR_FORMAT = 6;
	localparam int DPDA_ST_SELECTED = 0;
	localparam int DPDA_ST_RESERVED = 2;
	localparam int DPDA_ST_PRIO_RESERVED = 4;
	localparam int DPDA_ST_PENDING = 6;
	localparam int DPDA_ST_ACTIVE = 8;
	localparam int DPDA_ST_TIME_DEP = 9;
	localparam int DPDA_ST_FMT_EXCEPTION = 10;
	localparam int DPDA_ST_FMT_USABLE = 11;
	localparam int DPDA_ST_NEUTRAL = 12;

	// ----------------------------------------------------------------
	// Format constants and reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] DPDA_ALL_ONES = 16'hFFFF;
	localparam logic [15:0] DPDA_MAX_FIELDS = 16'h0003;
	localparam logic [15:0] DPDA_MFR_FIELDS = 16'h0002;
	localparam logic [7:0] DPDA_RST_FLAGS = 8'h00;
	localparam logic [15:0] DPDA_RST_SECTORS = 16'hFFFF;
	localparam logic [15:0] DPDA_RST_FIELDS = 16'hFFFF;

endpackage

// ==== verilog/dpda_top.sv ====
// Dual port drive access control: selection arbitration, port switch,
// reservations, command activity, status pending and format handling.
// Assumes port strobes are synchronous to pclk and one cycle long.
//
// Function
// - Commands needing the format are refused unless initialized flag set.
// - Initialized flag is bit 7 of the format flag octet.
// - Loaded format survives controller and drive resets.
// - Missing or bad format parameters set the format exception bit.
// - Flag bit 6 selects built-in format until next load.
// - Built-in format is one header plus one data field.
// - Not ready drive rejects head assembly work, out of context.
// - Busy when other port selected or reserved, active or timed.
// - Command stays active until completion; no new command meanwhile.
// - At most one port selected; simultaneous requests arbitrated.
// - Busy selection answers slave in without radial address.
// - Reservation holds until release, reset or other priority select.
// - Priority reservation is not broken by any priority select.
// - Timed command keeps other port busy; owner gets status busy.
// - Completion raises class 1 interrupt to owner, clears busy.
// - Neutral drive accepts access through either enabled port.
// - Selection or priority select switches; reserve keeps it.
// - Switch released on deselect unreserved, reset, priority select.
// - Drive reset drops selections, reservations, pending and activity; format kept.
// - Status pending held until the controller collects status.
//
// Register access over APB and the placing of the registers are this design's own decisions.
module dpda_top #(
	parameter logic [15:0] DEF_SECTORS = 16'h0020,
	parameter logic [15:0] DEF_FIELDS = 16'h0002,
	parameter logic [15:0] MFR_SECTORS = 16'h0020
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic drive_ready,
	input wire logic [1:0] port_enabled,
	input wire logic [1:0] sel_req,
	input wire logic [1:0] prio_select,
	input wire logic [1:0] reserve,
	input wire logic [1:0] prio_reserve,
	input wire logic [1:0] release_req,
	input wire logic [1:0] port_reset,
	input wire logic [1:0] cmd_valid,
	input wire logic [1:0] cmd_time_dep,
	input wire logic [1:0] cmd_needs_hda,
	input wire logic [1:0] cmd_needs_format,
	input wire logic time_dep_done,
	input wire logic [1:0] status_taken,
	output logic [1:0] slave_in,
	output logic [1:0] radial_addr_valid,
	output logic [1:0] selected,
	output logic [1:0] switched,
	output logic [1:0] cmd_accept,
	output logic [1:0] status_busy,
	output logic [1:0] op_exception,
	output logic [1:0] out_of_context,
	output logic [1:0] completion_irq,
	output logic [1:0] status_pending,
	output logic cmd_active
);
	import dpda_pkg::*;

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (DEF_FIELDS == 16'h0000 || DEF_FIELDS > DPDA_MAX_FIELDS) begin
		$error("DEF_FIELDS must be 1 to 3");
	end
	if (DEF_SECTORS == 16'h0000 || DEF_SECTORS > 16'h0100) begin
		$error("DEF_SECTORS must be 1 to 256");
	end
	if (MFR_SECTORS == 16'h0000 || MFR_SECTORS > 16'h0100) begin
		$error("MFR_SECTORS must be 1 to 256");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [1:0] sel;
		logic [1:0] res;
		logic [1:0] pres;
		logic last_win;
		logic active;
		logic time_dep;
		logic cmd_port;
		logic [1:0] pend;
		logic [1:0] slave_in;
		logic [1:0] radial;
		logic [1:0] switched;
		logic [1:0] accept;
		logic [1:0] st_busy;
		logic [1:0] op_exc;
		logic [1:0] oop;
		logic [1:0] irq;
		logic [7:0] stg_flags;
		logic [15:0] stg_sectors;
		logic [15:0] stg_fields;
		logic [7:0] fmt_flags;
		logic [15:0] fmt_sectors;
		logic [15:0] fmt_fields;
		logic fmt_exc;
	} dpda_state_type;

	dpda_state_type state;
	dpda_state_type next_state;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic dpda_fields_ok(input logic [15:0] f);
		dpda_fields_ok = (f != 16'h0000) && (f <= DPDA_MAX_FIELDS);
	endfunction

	function automatic logic dpda_known(input logic [15:0] v);
		dpda_known = (v != DPDA_ALL_ONES);
	endfunction

	logic wr_en;
	logic rd_en;
	logic fmt_usable;
	logic [1:0] owns;
	logic [1:0] busy;
	logic [1:0] want;
	logic [1:0] grant;
	logic [1:0] broken;
	logic drive_rst;
	logic [15:0] ld_sectors;
	logic [15:0] ld_fields;
	logic [31:0] rd_word;
	logic rd_hit;
	int p;
	int q;

	always_comb begin
		next_state = state;
		wr_en = psel && penable && pwrite && !state.pready;
		rd_en = psel && penable && !pwrite && !state.pready;
		ld_sectors = state.stg_sectors;
		ld_fields = state.stg_fields;
		rd_word = 32'h0000_0000;
		rd_hit = 1'b1;
		drive_rst = wr_en && (paddr == DPDA_OFF_CTRL) &&
			pwdata[DPDA_CTRL_DRIVE_RESET];
		fmt_usable = state.fmt_flags[DPDA_FLAG_INITIALIZED];
		owns = state.sel | state.res | state.pres;
		broken = 2'b00;
		grant = 2'b00;
		next_state.accept = 2'b00;
		next_state.st_busy = 2'b00;
		next_state.op_exc = 2'b00;
		next_state.oop = 2'b00;
		next_state.irq = 2'b00;

		// ------------------------------------------------------------
		// APB slave, one wait state
		// ------------------------------------------------------------
		next_state.pready = psel && penable && !state.pready;
		next_state.pslverr = 1'b0;
		case (paddr)
			DPDA_OFF_CTRL: rd_word = 32'h0000_0000;
			DPDA_OFF_STATUS: begin
				rd_word[DPDA_ST_SELECTED +: 2] = state.sel;
				rd_word[DPDA_ST_RESERVED +: 2] = state.res;
				rd_word[DPDA_ST_PRIO_RESERVED +: 2] = state.pres;
				rd_word[DPDA_ST_PENDING +: 2] = state.pend;
				rd_word[DPDA_ST_ACTIVE] = state.active;
				rd_word[DPDA_ST_TIME_DEP] = state.time_dep;
				rd_word[DPDA_ST_FMT_EXCEPTION] = state.fmt_exc;
				rd_word[DPDA_ST_FMT_USABLE] = fmt_usable;
				rd_word[DPDA_ST_NEUTRAL] = (owns == 2'b00);
			end
			// Reads return the active format so software sees what
			// the drive filled in
			DPDA_OFF_FMT_FLAGS: rd_word[7:0] = state.fmt_flags;
			DPDA_OFF_FMT_SECTORS: rd_word[15:0] = state.fmt_sectors;
			DPDA_OFF_FMT_FIELDS: rd_word[15:0] = state.fmt_fields;
			DPDA_OFF_FMT_LOAD: rd_word = 32'h0000_0000;
			default: rd_hit = 1'b0;
		endcase
		if (rd_en) begin
			next_state.prdata = rd_hit ? rd_word : 32'h0000_0000;
			next_state.pslverr = !rd_hit;
		end
		if (wr_en) begin
			case (paddr)
				DPDA_OFF_CTRL: ;
				DPDA_OFF_STATUS: next_state.pslverr = 1'b1;
				DPDA_OFF_FMT_FLAGS: next_state.stg_flags = pwdata[7:0];
				DPDA_OFF_FMT_SECTORS:
					next_state.stg_sectors = pwdata[15:0];
				DPDA_OFF_FMT_FIELDS: next_state.stg_fields = pwdata[15:0];
				DPDA_OFF_FMT_LOAD: ;
				default: next_state.pslverr = 1'b1;
			endcase
		end

		// ------------------------------------------------------------
		// Format load
		// ------------------------------------------------------------
		if (wr_en && paddr == DPDA_OFF_FMT_LOAD) begin
			next_state.fmt_exc = 1'b0;
			if (state.stg_flags[DPDA_FLAG_MFR_FORMAT]) begin
				// Built-in layout: header plus one data field
				next_state.fmt_flags = state.stg_flags;
				next_state.fmt_flags[DPDA_FLAG_INITIALIZED] = 1'b1;
				next_state.fmt_sectors = MFR_SECTORS;
				next_state.fmt_fields = DPDA_MFR_FIELDS;
			end else begin
				if (!state.stg_flags[DPDA_FLAG_INITIALIZED]) begin
					// Drive fills the quantities left as all ones
					if (!dpda_known(state.stg_sectors)) begin
						ld_sectors = DEF_SECTORS;
					end
					if (!dpda_known(state.stg_fields)) begin
						ld_fields = DEF_FIELDS;
					end
				end
				next_state.fmt_flags = state.stg_flags;
				next_state.fmt_sectors = ld_sectors;
				next_state.fmt_fields = ld_fields;
				if (!dpda_known(ld_sectors) || ld_sectors == 16'h0000 ||
					!dpda_fields_ok(ld_fields)) begin
					// Incomplete spec stays unusable
					next_state.fmt_exc = 1'b1;
					next_state.fmt_flags[DPDA_FLAG_INITIALIZED] = 1'b0;
				end else begin
					next_state.fmt_flags[DPDA_FLAG_INITIALIZED] = 1'b1;
				end
			end
		end

		// ------------------------------------------------------------
		// Arbitration and port switch
		// ------------------------------------------------------------
		for (p = 0; p < 2; p++) begin
			q = 1 - p;
			// Deselection drops selection; reservation keeps switch
			if (!sel_req[p]) begin
				next_state.sel[p] = 1'b0;
			end
			if (state.sel[p] && release_req[p]) begin
				next_state.res[p] = 1'b0;
				next_state.pres[p] = 1'b0;
			end
			if (state.sel[p] && reserve[p]) begin
				next_state.res[p] = 1'b1;
			end
			if (state.sel[p] && prio_reserve[p]) begin
				next_state.pres[p] = 1'b1;
			end
			// A priority select steals a plain reservation only
			if (sel_req[p] && prio_select[p] && port_enabled[p] &&
				!state.pres[q] && !state.sel[p]) begin
				broken[q] = 1'b1;
			end
		end
		for (p = 0; p < 2; p++) begin
			q = 1 - p;
			busy[p] = state.sel[q] || state.res[q] || state.pres[q] ||
				state.active || state.time_dep;
			want[p] = sel_req[p] && port_enabled[p] && !state.sel[p] &&
				(!busy[p] || broken[q]);
		end
		// Simultaneous requests: the port not granted last time wins
		if (want == 2'b11) begin
			grant[state.last_win ? 0 : 1] = 1'b1;
		end else begin
			grant = want;
		end
		for (p = 0; p < 2; p++) begin
			q = 1 - p;
			if (broken[p] && grant[q]) begin
				next_state.sel[p] = 1'b0;
				next_state.res[p] = 1'b0;
				next_state.pres[p] = 1'b0;
			end
			if (grant[p]) begin
				next_state.sel[p] = 1'b1;
				next_state.last_win = p[0];
			end
		end

		// ------------------------------------------------------------
		// Commands, completion and status pending
		// ------------------------------------------------------------
		for (p = 0; p < 2; p++) begin
			if (cmd_valid[p] && state.sel[p]) begin
				if (state.active || state.time_dep) begin
					next_state.st_busy[p] = 1'b1;
				end else if (cmd_needs_hda[p] && !drive_ready) begin
					next_state.op_exc[p] = 1'b1;
					next_state.oop[p] = 1'b1;
					next_state.pend[p] = 1'b1;
				end else if (cmd_needs_format[p] && !fmt_usable) begin
					next_state.op_exc[p] = 1'b1;
					next_state.pend[p] = 1'b1;
				end else begin
					next_state.accept[p] = 1'b1;
					next_state.cmd_port = p[0];
					if (cmd_time_dep[p]) begin
						next_state.active = 1'b1;
						next_state.time_dep = 1'b1;
					end else begin
						next_state.pend[p] = 1'b1;
					end
				end
			end
		end
		if (state.time_dep && time_dep_done) begin
			// Class 1 interrupt to the owning port; busy lifts on both
			next_state.active = 1'b0;
			next_state.time_dep = 1'b0;
			next_state.irq[state.cmd_port] = 1'b1;
			next_state.pend[state.cmd_port] = 1'b1;
		end
		for (p = 0; p < 2; p++) begin
			// Status arriving in the collection cycle stays pending
			if (status_taken[p] && !next_state.pend[p]) begin
				next_state.pend[p] = 1'b0;
			end else if (status_taken[p] && state.pend[p] &&
				!next_state.irq[p] && !next_state.op_exc[p] &&
				!next_state.accept[p]) begin
				next_state.pend[p] = 1'b0;
			end
		end

		// ------------------------------------------------------------
		// Resets; the format is kept as stored state
		// ------------------------------------------------------------
		for (p = 0; p < 2; p++) begin
			q = 1 - p;
			if (port_reset[p] || !port_enabled[p]) begin
				next_state.sel[p] = 1'b0;
				next_state.res[p] = 1'b0;
				next_state.pres[p] = 1'b0;
				next_state.pend[p] = 1'b0;
				if (!(owns[q])) begin
					next_state.active = 1'b0;
					next_state.time_dep = 1'b0;
				end
			end
		end
		if (drive_rst) begin
			next_state.sel = 2'b00;
			next_state.res = 2'b00;
			next_state.pres = 2'b00;
			next_state.pend = 2'b00;
			next_state.active = 1'b0;
			next_state.time_dep = 1'b0;
			next_state.irq = 2'b00;
			next_state.accept = 2'b00;
		end

		// ------------------------------------------------------------
		// Port indications
		// ------------------------------------------------------------
		for (p = 0; p < 2; p++) begin
			// Busy answer: slave in without radial address
			next_state.slave_in[p] = sel_req[p] && port_enabled[p];
			next_state.radial[p] = next_state.sel[p];
		end
		next_state.switched = next_state.sel | next_state.res |
			next_state.pres;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '0;
			state.stg_sectors <= DPDA_RST_SECTORS;
			state.stg_fields <= DPDA_RST_FIELDS;
			state.fmt_flags <= DPDA_RST_FLAGS;
			state.fmt_sectors <= DPDA_RST_SECTORS;
			state.fmt_fields <= DPDA_RST_FIELDS;
		end else begin
			state <= next_state;
		end
	end

	assign prdata = state.prdata;
	assign pready = state.pready;
	assign pslverr = state.pslverr;
	assign slave_in = state.slave_in;
	assign radial_addr_valid = state.radial;
	assign selected = state.sel;
	assign switched = state.switched;
	assign cmd_accept = state.accept;
	assign status_busy = state.st_busy;
	assign op_exception = state.op_exc;
	assign out_of_context = state.oop;
	assign completion_irq = state.irq;
	assign status_pending = state.pend;
	assign cmd_active = state.active;

endmodule
